// >>> rtl/branch_and_bit_set_exec.sv
// execution of the unconditional relative jump and the file bit set
//
// Behaviour
// - jump offset is signed 11 bits, -1024..1023, doubled to bytes
// - jump loads PC with PC + 2 + 2n, no status flag changes
// - jump decoded from opcode 1101 then a zero bit, low 11 bits offset
// - jump is one word and takes two instruction cycles
// - bit set (opcode 1000, bbb, a, ffffffff) forces chosen bit to one
// - access bit 0 selects the fixed access bank
// - access bit 1 takes the bank from the bank select register
// - extended set, a=0 and f up to 5Fh use indexed literal offset
`timescale 1ns/1ps
`default_nettype none
module branch_and_bit_set_exec
  import jump_bitset_pkg::*;
(
  input  wire logic                              mclk_i,
  input  wire logic                              rst_i,
  input  wire logic [15:0]                       instr_i,
  input  wire logic                              instr_valid_i,
  input  wire logic [jump_bitset_pkg::PC_W-1:0]  pc_i,
  input  wire logic [3:0]                        bank_sel_reg_i,
  input  wire logic [jump_bitset_pkg::ADDR_W-1:0] index_base_i,
  input  wire logic                              ext_en_i,
  input  wire logic [7:0]                        mem_rdata_i,
  output logic                                   instr_ready_o,
  output logic [1:0]                             phase_o,
  output logic                                   pc_load_o,
  output logic [jump_bitset_pkg::PC_W-1:0]       pc_target_o,
  output logic                                   mem_rd_o,
  output logic                                   mem_wr_o,
  output logic [jump_bitset_pkg::ADDR_W-1:0]     mem_addr_o,
  output logic [7:0]                             mem_wdata_o
);
  import jump_bitset_pkg::*;

  phase_t            ph_q;
  op_t               op_q;
  logic              nop_cycle_q;
  logic [2:0]        bit_q;
  logic [7:0]        rdata_q;
  logic              pc_load_q;
  logic [PC_W-1:0]   pc_target_q;
  logic              mem_rd_q;
  logic              mem_wr_q;
  logic [ADDR_W-1:0] mem_addr_q;
  logic [7:0]        mem_wdata_q;
  logic              is_jump;
  logic              is_set;
  logic              take;
  logic [PC_W-1:0]   offs_bytes;
  logic [PC_W-1:0]   target_d;
  logic [7:0]        set_mask;

  file_addr_if ai ();

  file_addr_calc i_file_addr_calc (
    .ai (ai.calc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode
  assign is_jump = (instr_i[OPC_HI:OPC_LO] == JUMP_NIBBLE) && (instr_i[SEL_POS] == JUMP_SEL_BIT);
  assign is_set  = (instr_i[OPC_HI:OPC_LO] == SET_NIBBLE);
  // second cycle of a jump accepts nothing
  assign instr_ready_o = (ph_q == Q1) && !nop_cycle_q;
  assign take          = instr_ready_o && instr_valid_i;

  // sign extend and double the offset
  assign offs_bytes = {{(PC_W-OFFS_W-1){instr_i[OFFS_W-1]}}, instr_i[OFFS_W-1:0], 1'b0};
  assign target_d   = pc_i + PC_STEP + offs_bytes;
  assign set_mask   = 8'h01 << bit_q;

  assign ai.file_addr  = instr_i[FILE_HI:0];
  assign ai.access     = instr_i[ACC_POS];
  assign ai.bank       = bank_sel_reg_i;
  assign ai.index_base = index_base_i;
  assign ai.ext_en     = ext_en_i;

  ////////////////////////////////////////////////////////////////////////////
  // quarter phase sequencer
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ph_q <= Q1;
    end else begin
      case (ph_q)
        Q1:      ph_q <= Q2;
        Q2:      ph_q <= Q3;
        Q3:      ph_q <= Q4;
        Q4:      ph_q <= Q1;
        default: ph_q <= Q1;
      endcase
    end
  end
  assign phase_o = ph_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      op_q  <= OP_NONE;
      bit_q <= 3'h0;
    end else if (take) begin
      op_q  <= is_jump ? OP_JUMP : (is_set ? OP_SET : OP_NONE);
      bit_q <= instr_i[BIT_HI:BIT_LO];
    end else if (ph_q == Q4) begin
      op_q  <= OP_NONE;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      nop_cycle_q <= 1'b0;
    end else if (ph_q == Q4) begin
      nop_cycle_q <= (op_q == OP_JUMP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // jump: target held from decode, PC written during Q4
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pc_target_q <= '0;
    end else if (take && is_jump) begin
      pc_target_q <= target_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pc_load_q <= 1'b0;
    end else begin
      pc_load_q <= (ph_q == Q3) && (op_q == OP_JUMP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit set: read in Q2, modify in Q3, write in Q4
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mem_addr_q <= '0;
    end else if (take && is_set) begin
      mem_addr_q <= ai.addr;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mem_rd_q <= 1'b0;
    end else begin
      mem_rd_q <= take && is_set;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (mem_rd_q) begin
      rdata_q <= mem_rdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mem_wr_q    <= 1'b0;
      mem_wdata_q <= 8'h00;
    end else begin
      mem_wr_q <= (ph_q == Q3) && (op_q == OP_SET);
      if ((ph_q == Q3) && (op_q == OP_SET)) begin
        mem_wdata_q <= rdata_q | set_mask;
      end
    end
  end

  assign pc_load_o   = pc_load_q;
  assign pc_target_o = pc_target_q;
  assign mem_rd_o    = mem_rd_q;
  assign mem_wr_o    = mem_wr_q;
  assign mem_addr_o  = mem_addr_q;
  assign mem_wdata_o = mem_wdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  logic take_jump;
  logic take_set;
  logic [7:0] mask_now;
  assign take_jump = take && is_jump;
  assign take_set  = take && is_set;
  assign mask_now  = 8'h01 << instr_i[BIT_HI:BIT_LO];

  jump_target_a: assert property (take_jump |-> ##3 (pc_load_o && pc_target_o == $past(target_d, 3)))
    else $error("jump target wrong or late");
  jump_offset_a: assert property (take_jump |=> pc_target_o - $past(pc_i) - PC_STEP
                                  == {{(PC_W-OFFS_W-1){$past(instr_i[10])}}, $past(instr_i[10:0]), 1'b0})
    else $error("jump offset not doubled signed value");
  jump_nop_a: assert property (pc_load_o |=> (!instr_ready_o && !mem_rd_o && !mem_wr_o)[*4] ##1 instr_ready_o)
    else $error("second jump cycle not idle");
  jump_quiet_a: assert property (take_jump |-> ##1 (!mem_rd_o && !mem_wr_o)[*7])
    else $error("jump touched data memory");
  set_seq_a: assert property (take_set |=> mem_rd_o && !mem_wr_o ##1 !mem_rd_o && !mem_wr_o
                              ##1 mem_wr_o && !pc_load_o ##1 !mem_wr_o && instr_ready_o)
    else $error("bit set phase sequence wrong");
  set_data_a: assert property (take_set |-> ##3 mem_wdata_o == ($past(mem_rdata_i, 2) | $past(mask_now, 3)))
    else $error("bit set data wrong");
  bank_sel_a: assert property (take_set && instr_i[8] |=> mem_addr_o == {$past(bank_sel_reg_i), $past(instr_i[7:0])})
    else $error("banked address wrong");
  access_bank_a: assert property (take_set && !instr_i[8] && !(ext_en_i && instr_i[7:0] <= ACCESS_LIMIT)
                                  |=> mem_addr_o[7:0] == $past(instr_i[7:0])
                                      && mem_addr_o[11:8] == ($past(instr_i[7:0]) <= ACCESS_LIMIT
                                                              ? ACCESS_LO_BNK : ACCESS_HI_BNK))
    else $error("access bank address wrong");
  indexed_mode_a: assert property (take_set && !instr_i[8] && ext_en_i && instr_i[7:0] <= ACCESS_LIMIT
                                   |=> mem_addr_o == $past(index_base_i) + {4'h0, $past(instr_i[7:0])})
    else $error("indexed address wrong");

  jump_cov_c:    cover property (take_jump ##8 take_set);
  set_cov_c:     cover property (take_set ##4 take_set);
  indexed_cov_c: cover property (take_set && ext_en_i && !instr_i[8] && instr_i[7:0] <= ACCESS_LIMIT);
endmodule // branch_and_bit_set_exec
`default_nettype wire

// >>> rtl/jump_bitset_pkg.sv
// constants and types shared by the branch and bit-set execution logic
package jump_bitset_pkg;
  localparam int          PC_W          = 21;
  localparam int          ADDR_W        = 12;
  localparam int          OFFS_W        = 11;
  localparam int          OPC_HI        = 15;
  localparam int          OPC_LO        = 12;
  localparam int          SEL_POS       = 11;
  localparam int          BIT_HI        = 11;
  localparam int          BIT_LO        = 9;
  localparam int          ACC_POS       = 8;
  localparam int          FILE_HI       = 7;
  localparam logic [3:0]  JUMP_NIBBLE   = 4'hD;
  localparam logic        JUMP_SEL_BIT  = 1'b0;
  localparam logic [3:0]  SET_NIBBLE    = 4'h8;
  localparam logic [7:0]  ACCESS_LIMIT  = 8'h5F;
  localparam logic [3:0]  ACCESS_LO_BNK = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BNK = 4'hF;
  localparam logic [PC_W-1:0] PC_STEP   = 21'h000002;
  localparam logic        ACC_BANKED    = 1'b1;

  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b10,
    Q4 = 2'b11
  } phase_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_JUMP = 2'b01,
    OP_SET  = 2'b10
  } op_t;
endpackage

// >>> rtl/file_addr_if.sv
// operand and result signals of the file address generator
`timescale 1ns/1ps
`default_nettype none
interface file_addr_if;
  import jump_bitset_pkg::*;
  logic [7:0]        file_addr;
  logic              access;
  logic [3:0]        bank;
  logic [ADDR_W-1:0] index_base;
  logic              ext_en;
  logic [ADDR_W-1:0] addr;
  logic              indexed;
  modport user (output file_addr, output access, output bank, output index_base, output ext_en,
                input addr, input indexed);
  modport calc (input file_addr, input access, input bank, input index_base, input ext_en,
                output addr, output indexed);
endinterface
`default_nettype wire

// >>> rtl/file_addr_calc.sv
// data memory address from file address, access bit, bank and index base
`timescale 1ns/1ps
`default_nettype none
module file_addr_calc (
  file_addr_if.calc ai
);
  import jump_bitset_pkg::*;

  logic low_half;

  assign low_half   = (ai.file_addr <= ACCESS_LIMIT);
  assign ai.indexed = ai.ext_en && (ai.access != ACC_BANKED) && low_half;

  always_comb begin
    if (ai.access == ACC_BANKED) begin
      ai.addr = {ai.bank, ai.file_addr};
    end else if (ai.indexed) begin
      ai.addr = ai.index_base + {4'h0, ai.file_addr};
    end else if (low_half) begin
      ai.addr = {ACCESS_LO_BNK, ai.file_addr};
    end else begin
      ai.addr = {ACCESS_HI_BNK, ai.file_addr};
    end
  end
endmodule // file_addr_calc
`default_nettype wire

// >>> dv/branch_and_bit_set_exec_tb.sv
// self-checking bench for the jump and file bit set execution logic
`timescale 1ns/1ps
`default_nettype none
module branch_and_bit_set_exec_tb;
  import jump_bitset_pkg::*;

  logic              mclk_i         = 1'b0;
  logic              rst_i          = 1'b1;
  logic [15:0]       instr_i        = 16'h0000;
  logic              instr_valid_i  = 1'b0;
  logic [PC_W-1:0]   pc_i           = 21'h000000;
  logic [3:0]        bank_sel_reg_i = 4'hA;
  logic [ADDR_W-1:0] index_base_i   = 12'h3C0;
  logic              ext_en_i       = 1'b0;
  logic [7:0]        mem_rdata_i    = 8'h00;
  logic              instr_ready_o;
  logic [1:0]        phase_o;
  logic              pc_load_o;
  logic [PC_W-1:0]   pc_target_o;
  logic              mem_rd_o;
  logic              mem_wr_o;
  logic [ADDR_W-1:0] mem_addr_o;
  logic [7:0]        mem_wdata_o;
  int                mismatches     = 0;
  int                comparisons    = 0;

  always #5 mclk_i = ~mclk_i;

  branch_and_bit_set_exec i_branch_and_bit_set_exec (
    .mclk_i(mclk_i), .rst_i(rst_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i), .pc_i(pc_i),
    .bank_sel_reg_i(bank_sel_reg_i), .index_base_i(index_base_i), .ext_en_i(ext_en_i),
    .mem_rdata_i(mem_rdata_i), .instr_ready_o(instr_ready_o), .phase_o(phase_o), .pc_load_o(pc_load_o),
    .pc_target_o(pc_target_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %0b seen %0b", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [20:0] exp, input logic [20:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // waits for a Q1 slot, offers the word for one edge, returns in Q2
  task automatic issue(input logic [15:0] ins, input logic [20:0] pc);
    int n;
    n = 0;
    while (!(phase_o === 2'b00 && instr_ready_o === 1'b1) && n < 20) begin
      @(negedge mclk_i);
      n++;
    end
    chk_bit("ready before take", 1'b1, instr_ready_o);
    instr_i = ins;
    pc_i = pc;
    instr_valid_i = 1'b1;
    @(negedge mclk_i);
    instr_valid_i = 1'b0;
  endtask

  task automatic bit_set(input logic a, input logic [2:0] b, input logic [7:0] f,
                         input logic [11:0] exp_addr, input logic [7:0] rd);
    mem_rdata_i = rd;
    issue({4'h8, b, a, f}, 21'h000100);
    chk_bit("read strobe q2", 1'b1, mem_rd_o);
    chk_word("phase after take", 21'h000001, {19'h00000, phase_o});
    chk_word("data address", {9'h000, exp_addr}, {9'h000, mem_addr_o});
    chk_bit("write strobe q2", 1'b0, mem_wr_o);
    @(negedge mclk_i);
    chk_bit("read strobe q3", 1'b0, mem_rd_o);
    @(negedge mclk_i);
    chk_bit("write strobe q4", 1'b1, mem_wr_o);
    chk_word("write data", {13'h0000, rd | (8'h01 << b)}, {13'h0000, mem_wdata_o});
    @(negedge mclk_i);
    chk_bit("write strobe q1", 1'b0, mem_wr_o);
  endtask

  task automatic jump(input logic [10:0] n, input logic [20:0] pc);
    logic [20:0] exp;
    exp = pc + 21'h000002 + {{9{n[10]}}, n, 1'b0};
    issue({4'hD, 1'b0, n}, pc);
    chk_word("jump target", exp, pc_target_o);
    chk_bit("pc load q2", 1'b0, pc_load_o);
    @(negedge mclk_i);
    chk_bit("pc load q3", 1'b0, pc_load_o);
    @(negedge mclk_i);
    chk_bit("pc load q4", 1'b1, pc_load_o);
    // a bit set offered during the idle cycle must be refused
    instr_i = 16'h8E20;
    instr_valid_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(negedge mclk_i);
      chk_bit("ready second cycle", 1'b0, instr_ready_o);
      chk_bit("pc load second cycle", 1'b0, pc_load_o);
      chk_bit("read second cycle", 1'b0, mem_rd_o);
      instr_valid_i = (i < 3);
    end
    @(negedge mclk_i);
    chk_bit("ready after jump", 1'b1, instr_ready_o);
  endtask

  task automatic other_op(input logic [15:0] ins);
    issue(ins, 21'h000200);
    repeat (3) begin
      chk_bit("no pc load", 1'b0, pc_load_o);
      chk_bit("no write", 1'b0, mem_wr_o);
      @(negedge mclk_i);
    end
    chk_bit("ready next cycle", 1'b1, instr_ready_o);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge mclk_i);
    chk_word("phase in reset", 21'h000000, {19'h00000, phase_o});
    chk_bit("pc load in reset", 1'b0, pc_load_o);
    rst_i = 1'b0;
    for (int b = 0; b < 8; b++)
      bit_set(1'b1, b[2:0], 8'hF3, 12'hAF3, 8'h5A ^ 8'(b));
    bit_set(1'b0, 3'd7, 8'h5F, 12'h05F, 8'h0A);
    bit_set(1'b0, 3'd1, 8'h60, 12'hF60, 8'h00);
    ext_en_i = 1'b1;
    bit_set(1'b0, 3'd2, 8'h5F, 12'h41F, 8'h81);
    bit_set(1'b0, 3'd0, 8'h00, 12'h3C0, 8'hFE);
    bit_set(1'b0, 3'd3, 8'h60, 12'hF60, 8'h00);
    bit_set(1'b1, 3'd4, 8'h10, 12'hA10, 8'h00);
    jump(11'h3FF, 21'h000100);
    jump(11'h400, 21'h000800);
    jump(11'h7FF, 21'h000000);
    jump(11'h000, 21'h1FFFFE);
    other_op(16'hD800);
    other_op(16'h9F12);
    tally_and_finish();
  end

  initial begin
    #50000;
    mismatches++;
    $display("mismatch watchdog expected finish seen hang");
    tally_and_finish();
  end
endmodule // branch_and_bit_set_exec_tb
`default_nettype wire
